// ### core/wcc_aon_mem.sv
`timescale 1ns/1ps
`default_nettype none
module wcc_aon_mem
   import wcc_pkg::*;
#(
   parameter int WORDS = 4
)(
   input  wire logic clock,  // System clock.
   input  wire logic srst,   // Synchronous reset, active high.
   input  wire logic ce,     // Clock enable.
   wcc_mem_if.mem    m       // Store port from the controller.
);
   logic [31:0] store [WORDS];
   logic [31:0] dr_word;
   logic [5:0]  dr_widx;

   // The store is retained memory, so reset leaves its contents alone.
   always_ff @(posedge clock)
   begin
      if (ce && m.wr_en)
      begin
         store[m.wr_idx] <= m.wr_data;
      end
   end

   assign m.rd_data = store[m.rd_idx];

   // Direct read returns zero above the populated words.
   assign dr_widx = m.dr_addr[7:2];
   assign dr_word = (int'(dr_widx) < WORDS) ? store[dr_widx[$clog2(WORDS)-1:0]] : 32'h0000_0000;
   assign m.dr_byte = dr_word[{m.dr_addr[1:0], 3'h0} +: 8];

   // Upload copies the two host-side config words into the live copies.
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         m.cfg0_q <= CFG_RST;
         m.cfg1_q <= CFG_RST;
      end
      else if (ce && m.upl)
      begin
         m.cfg0_q <= m.cfg0;
         m.cfg1_q <= m.cfg1;
      end
   end
endmodule
`default_nettype wire

// ### core/wcc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module wcc_ctrl
   import wcc_pkg::*;
#(
   parameter int WORDS       = 4,   // User configuration words kept in the store.
   parameter int UCODE_WORDS = 64   // Microcode words copied on wake.
)(
   input  wire logic               clock,                // 100 MHz system clock.
   input  wire logic               srst,                 // Synchronous reset, active high.
   input  wire logic               ce,                   // Clock enable; low freezes all.
   input  wire logic               psel,                 // APB select.
   input  wire logic               penable,              // APB enable.
   input  wire logic               pwrite,               // APB write.
   input  wire logic [9:0]         paddr,                // APB byte address.
   input  wire logic [31:0]        pwdata,               // APB write data.
   output logic [31:0]             prdata,               // APB read data.
   output logic                    pready,               // APB ready.
   output logic                    pslverr,              // APB error on unmapped address.
   input  wire logic               wake_pin,             // Asynchronous wake request.
   output logic                    otp_rd_req,           // OTP read pulse.
   output logic [7:0]              otp_rd_addr,          // OTP word address.
   input  wire logic [31:0]        otp_rd_data,          // OTP read data.
   input  wire logic               otp_rd_valid,         // OTP data valid.
   output logic                    ucode_ram_we,         // Microcode RAM write.
   output logic [15:0]             ucode_ram_addr,       // Microcode ROM and RAM address.
   output logic                    long_preamble_param_set, // Length-64 set selected.
   output logic                    sleep_after_receive,  // Auto sleep after receive.
   output logic                    sleep_after_transmit, // Auto sleep after transmit.
   output logic [31:0]             regulator_tuning,     // Regulator trim value.
   output logic [31:0]             always_on_config_zero_live,        // Live always-on config zero.
   output logic [31:0]             always_on_config_one_live,        // Live always-on config one.
   output logic [WORDS*32-1:0]     user_cfg,             // User configuration words.
   output logic                    wake_done             // Wake complete pulse.
);
   localparam int IW = $clog2(WORDS);

   typedef enum logic [3:0] {
      ST_IDLE      = 4'b0000,
      ST_WAKE_CFG  = 4'b0001,
      ST_UCODE     = 4'b0010,
      ST_TRIM_REQ  = 4'b0011,
      ST_TRIM_WAIT = 4'b0100,
      ST_WAKE_DONE = 4'b0101,
      ST_RESTORE   = 4'b0110,
      ST_SAVE      = 4'b0111,
      ST_SAVE_UPL  = 4'b1000,
      ST_DREAD     = 4'b1001
   } wcc_state_type;

   wcc_state_type state_r;
   logic [15:0]   cnt_r;
   logic [15:0]   wake_cfg_r;
   logic [7:0]    cmd_r;
   logic [7:0]    cmd_nxt;
   logic [7:0]    rdat_r;
   logic [7:0]    addr_r;
   logic [31:0]   cfg0_r;
   logic [31:0]   cfg1_r;
   logic [31:0]   user_r [WORDS];
   logic [2:0]    wake_sync_r;
   logic          wake_pend_r;
   logic          upl_cmd_r;
   logic          wr_acc;
   logic          rd_phase;
   logic          cfg_last;
   logic          user_hit;
   logic [7:0]    idx;
   logic [31:0]   rd_mux;
   logic          rd_err;
   wcc_state_type after_cfg;
   wcc_state_type after_ucode;

   wcc_mem_if #(.IW(IW)) mif ();

   wcc_aon_mem #(.WORDS(WORDS)) u_store (
      .clock (clock),
      .srst  (srst),
      .ce    (ce),
      .m     (mif.mem)
   );

   // Bus phase decode; a write takes effect only at the edge with pready high.
   assign idx      = paddr[9:2];
   assign rd_phase = psel && penable && !pready;
   assign wr_acc   = psel && penable && pready && pwrite;
   assign user_hit = (idx >= IDX_USER_BASE) && (int'(idx - IDX_USER_BASE) < WORDS);
   assign cfg_last = (cnt_r[IW-1:0] == IW'(WORDS - 1));

   // Store port wiring.
   assign mif.wr_en   = (state_r == ST_SAVE);
   assign mif.wr_idx  = cnt_r[IW-1:0];
   assign mif.wr_data = user_r[cnt_r[IW-1:0]];
   assign mif.rd_idx  = cnt_r[IW-1:0];
   assign mif.dr_addr = addr_r;
   assign mif.cfg0    = cfg0_r;
   assign mif.cfg1    = cfg1_r;
   assign mif.upl     = upl_cmd_r || (state_r == ST_SAVE_UPL);
   assign always_on_config_zero_live = mif.cfg0_q;
   assign always_on_config_one_live = mif.cfg1_q;

   // Wake pin passes three flops; an edge counts when the second flop is high and the third still low.
   always_ff @(posedge clock)
   begin
      if (srst)
         wake_sync_r <= 3'h0;
      else if (ce)
         wake_sync_r <= {wake_sync_r[1:0], wake_pin};
   end

   // A wake arriving while a command runs is held; the new edge wins over the clear.
   always_ff @(posedge clock)
   begin
      if (srst)
         wake_pend_r <= 1'b0;
      else if (ce)
      begin
         if (wake_sync_r[1] && !wake_sync_r[2])
            wake_pend_r <= 1'b1;
         else if (state_r == ST_IDLE)
            wake_pend_r <= 1'b0;
      end
   end

   // Optional wake steps are skipped when their enable bit is clear.
   // microcode step only when enabled
   always_comb
   begin
      after_ucode = wake_cfg_r[WCFG_TRIM] ? ST_TRIM_REQ : ST_WAKE_DONE;
      after_cfg   = wake_cfg_r[WCFG_UCODE] ? ST_UCODE : after_ucode;
   end

   // Sequencer; wake has priority over commands, then restore, save, direct read.
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         state_r <= ST_IDLE;
         cnt_r   <= 16'h0000;
      end
      else if (ce)
      begin
         case (state_r)
            ST_IDLE:
            begin
               cnt_r <= 16'h0000;
               if (wake_pend_r)
                  state_r <= ST_WAKE_CFG;
               else if (cmd_r[CMD_RESTORE])
                  state_r <= ST_RESTORE;
               else if (cmd_r[CMD_SAVE])
                  state_r <= ST_SAVE;
               else if (cmd_r[CMD_DREAD] && cmd_r[CMD_DEN])
                  state_r <= ST_DREAD;
            end
            ST_WAKE_CFG, ST_RESTORE, ST_SAVE:
            begin
               cnt_r <= cnt_r + 16'h0001;
               if (cfg_last)
               begin
                  cnt_r <= 16'h0000;
                  if (state_r == ST_WAKE_CFG)
                     state_r <= after_cfg;
                  else if (state_r == ST_SAVE)
                     state_r <= ST_SAVE_UPL;
                  else
                     state_r <= ST_IDLE;
               end
            end
            ST_UCODE:
            begin
               cnt_r <= cnt_r + 16'h0001;
               if (cnt_r == 16'(UCODE_WORDS - 1))
                  state_r <= after_ucode;
            end
            ST_TRIM_REQ:  state_r <= ST_TRIM_WAIT;
            // completion waits for the trim word
            ST_TRIM_WAIT: state_r <= otp_rd_valid ? ST_WAKE_DONE : ST_TRIM_WAIT;
            default:      state_r <= ST_IDLE;
         endcase
      end
   end

   // completion pulse after the last wake step
   always_ff @(posedge clock)
   begin
      if (srst)
         wake_done <= 1'b0;
      else if (ce)
         wake_done <= (state_r == ST_WAKE_DONE);
   end

   // Wake configuration and direct-access registers written by software.
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         wake_cfg_r <= WCFG_RST;
         addr_r     <= 8'h00;
         cfg0_r     <= CFG_RST;
         cfg1_r     <= CFG_RST;
      end
      else if (ce && wr_acc)
      begin
         if (idx == IDX_WAKE_CFG)
            wake_cfg_r <= pwdata[15:0] & WCFG_MASK;
         if (idx == IDX_ADDR)
            addr_r <= pwdata[7:0];
         if (idx == IDX_CFG0)
            cfg0_r <= pwdata;
         if (idx == IDX_CFG1)
            cfg1_r <= pwdata;
      end
   end

   // Self-clearing command bits; a software write in the same cycle wins.
   always_comb
   begin
      cmd_nxt = cmd_r;
      // hardware clears a bit as its command completes
      // restore clears after the last word
      if (state_r == ST_RESTORE && cfg_last)
         cmd_nxt[CMD_RESTORE] = 1'b0;
      if (state_r == ST_SAVE_UPL)
         cmd_nxt[CMD_SAVE] = 1'b0;
      if (state_r == ST_DREAD)
         cmd_nxt[CMD_DREAD] = 1'b0;
      if (wr_acc && idx == IDX_CMD)
         cmd_nxt = pwdata[7:0] & CMD_MASK;
   end

   // Upload bit stays set until software clears it, and fires on every write of one.
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         cmd_r     <= CMD_RST;
         upl_cmd_r <= 1'b0;
      end
      else if (ce)
      begin
         cmd_r     <= cmd_nxt;
         // each write of the upload bit copies once
         upl_cmd_r <= wr_acc && (idx == IDX_CMD) && pwdata[CMD_UPLOAD];
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
         rdat_r <= 8'h00;
      else if (ce && state_r == ST_DREAD)
         rdat_r <= mif.dr_byte;
   end

   // User configuration words, written by software or by wake and restore.
   generate
      for (genvar i = 0; i < WORDS; i++)
      begin : g_user
         always_ff @(posedge clock)
         begin
            if (srst)
               user_r[i] <= USER_RST;
            else if (ce)
            begin
               if (state_r == ST_WAKE_CFG && cnt_r[IW-1:0] == IW'(i))
               begin
                  user_r[i] <= wake_cfg_r[WCFG_RESTORE] ? mif.rd_data : USER_RST;
               end
               else if (state_r == ST_RESTORE && cnt_r[IW-1:0] == IW'(i))
                  user_r[i] <= mif.rd_data;
               else if (wr_acc && idx == IDX_USER_BASE + 8'(i))
                  user_r[i] <= pwdata;
            end
         end
         assign user_cfg[i*32 +: 32] = user_r[i];
      end
   endgenerate

   // Parameter set follows the wake bit; reset clears that bit, so reset picks default.
   always_ff @(posedge clock)
   begin
      if (srst)
         long_preamble_param_set <= 1'b0;
      else if (ce && state_r == ST_WAKE_CFG && cnt_r == 16'h0000)
      begin
         // length-64 set when bit is one
         // default set when bit is zero
         long_preamble_param_set <= wake_cfg_r[WCFG_LONG];
      end
   end

   // Sleep controls; software write loses to the wake clear only when both coincide.
   always_ff @(posedge clock)
   begin
      if (srst)
         {sleep_after_transmit, sleep_after_receive} <= SLP_RST;
      else if (ce)
      begin
         if (state_r == ST_WAKE_CFG && cnt_r == 16'h0000 && !wake_cfg_r[WCFG_KEEP])
            {sleep_after_transmit, sleep_after_receive} <= 2'h0;
         else if (wr_acc && idx == IDX_SLEEP)
         begin
            sleep_after_receive  <= pwdata[SLP_RX];
            sleep_after_transmit <= pwdata[SLP_TX];
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         ucode_ram_we   <= 1'b0;
         ucode_ram_addr <= 16'h0000;
      end
      else if (ce)
      begin
         ucode_ram_we   <= (state_r == ST_UCODE);
         ucode_ram_addr <= cnt_r;
      end
   end

   // fetch trim word and load the tuning register
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         otp_rd_req       <= 1'b0;
         otp_rd_addr      <= OTP_TRIM_ADDR;
         regulator_tuning <= REGTUNE_RST;
      end
      else if (ce)
      begin
         otp_rd_req <= (state_r == ST_TRIM_REQ);
         if (state_r == ST_TRIM_WAIT && otp_rd_valid)
            regulator_tuning <= otp_rd_data;
         else if (wr_acc && idx == IDX_REGTUNE)
            regulator_tuning <= pwdata;
      end
   end

   // Read multiplexer; unmapped indices answer with an error and zero data.
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      rd_err = 1'b0;
      if (user_hit)
         rd_mux = user_r[IW'(idx - IDX_USER_BASE)];
      else
      begin
         case (idx)
            IDX_WAKE_CFG: rd_mux = {16'h0000, wake_cfg_r};
            IDX_CMD:      rd_mux = {24'h000000, cmd_r};
            IDX_RDAT:     rd_mux = {24'h000000, rdat_r};
            IDX_ADDR:     rd_mux = {24'h000000, addr_r};
            IDX_CFG0:     rd_mux = cfg0_r;
            IDX_CFG1:     rd_mux = cfg1_r;
            IDX_SLEEP:    rd_mux = {30'h0, sleep_after_transmit, sleep_after_receive};
            IDX_STATUS:   rd_mux = {30'h0, long_preamble_param_set, state_r != ST_IDLE};
            IDX_REGTUNE:  rd_mux = regulator_tuning;
            IDX_ALWAYS_ON_CONFIG_ZERO: rd_mux = mif.cfg0_q;
            IDX_ALWAYS_ON_CONFIG_ONE: rd_mux = mif.cfg1_q;
            default:      rd_err = 1'b1;
         endcase
      end
   end

   // One wait cycle in every access keeps all bus outputs registered.
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else if (ce)
      begin
         pready  <= rd_phase;
         pslverr <= rd_phase && rd_err;
         if (rd_phase && !pwrite)
            prdata <= rd_mux;
      end
   end
endmodule
`default_nettype wire

// ### core/wcc_mem_if.sv
`timescale 1ns/1ps
`default_nettype none
interface wcc_mem_if #(parameter int IW = 2);
   logic          wr_en;     // Save one user word.
   logic [IW-1:0] wr_idx;    // Word being saved.
   logic [31:0]   wr_data;   // Saved word.
   logic [IW-1:0] rd_idx;    // Word being restored.
   logic [31:0]   rd_data;   // Restored word.
   logic [7:0]    dr_addr;   // Direct-read byte address.
   logic [7:0]    dr_byte;   // Direct-read byte.
   logic          upl;       // Upload pulse.
   logic [31:0]   cfg0;      // Host copy of always-on config zero.
   logic [31:0]   cfg1;      // Host copy of always-on config one.
   logic [31:0]   cfg0_q;    // Uploaded always-on config zero.
   logic [31:0]   cfg1_q;    // Uploaded always-on config one.

   modport ctrl (output wr_en, wr_idx, wr_data, rd_idx, dr_addr, upl, cfg0, cfg1,
                 input  rd_data, dr_byte, cfg0_q, cfg1_q);
   modport mem  (input  wr_en, wr_idx, wr_data, rd_idx, dr_addr, upl, cfg0, cfg1,
                 output rd_data, dr_byte, cfg0_q, cfg1_q);
endinterface
`default_nettype wire

// ### core/wcc_pkg.sv
package wcc_pkg;

   // Register indices; the byte address on APB is four times the index.
   localparam logic [7:0]  IDX_WAKE_CFG   = 8'h00;
   localparam logic [7:0]  IDX_CMD        = 8'h02;
   localparam logic [7:0]  IDX_RDAT       = 8'h03;
   localparam logic [7:0]  IDX_ADDR       = 8'h04;
   localparam logic [7:0]  IDX_CFG0       = 8'h06;
   localparam logic [7:0]  IDX_CFG1       = 8'h0a;
   localparam logic [7:0]  IDX_USER_BASE  = 8'h10;
   localparam logic [7:0]  IDX_SLEEP      = 8'h18;
   localparam logic [7:0]  IDX_STATUS     = 8'h19;
   localparam logic [7:0]  IDX_REGTUNE    = 8'h1a;
   localparam logic [7:0]  IDX_ALWAYS_ON_CONFIG_ZERO   = 8'h1b;
   localparam logic [7:0]  IDX_ALWAYS_ON_CONFIG_ONE   = 8'h1c;

   // Wake configuration field positions and writable mask.
   localparam int          WCFG_RESTORE   = 6;
   localparam int          WCFG_LONG      = 7;
   localparam int          WCFG_KEEP      = 8;
   localparam int          WCFG_UCODE     = 11;
   localparam int          WCFG_TRIM      = 12;
   localparam logic [15:0] WCFG_MASK      = 16'h19cb;
   localparam logic [15:0] WCFG_RST       = 16'h0000;

   // Command register fields; bits 6..4 are reserved and read zero.
   localparam int          CMD_RESTORE    = 0;
   localparam int          CMD_SAVE       = 1;
   localparam int          CMD_UPLOAD     = 2;
   localparam int          CMD_DREAD      = 3;
   localparam int          CMD_DEN        = 7;
   localparam logic [7:0]  CMD_MASK       = 8'h8f;
   localparam logic [7:0]  CMD_RST        = 8'h00;

   // Sleep control and status fields.
   localparam int          SLP_RX         = 0;
   localparam int          SLP_TX         = 1;
   localparam logic [1:0]  SLP_RST        = 2'h0;
   localparam int          STAT_BUSY      = 0;
   localparam int          STAT_LONG      = 1;

   // Reset values of the user configuration words and other stores.
   localparam logic [31:0] USER_RST       = 32'h0000_0000;
   localparam logic [31:0] CFG_RST        = 32'h0000_0000;
   localparam logic [31:0] REGTUNE_RST    = 32'h0000_0000;

   // One-time-programmable word that holds the regulator trim.
   localparam logic [7:0]  OTP_TRIM_ADDR  = 8'h04;

endpackage

// ### testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import wcc_pkg::*;
   logic clock, srst, psel, penable, pwrite, wake_pin, otp_rd_valid;
   logic [9:0] paddr;
   logic [31:0] pwdata, prdata, regulator_tuning, cfg0_live, cfg1_live, q;
   logic pready, pslverr, otp_rd_req, ucode_ram_we, wake_done, lp_set, s_rx, s_tx, e_q, ce;
   logic [7:0] otp_rd_addr;
   logic [15:0] ucode_ram_addr;
   logic [127:0] user_cfg, saved;
   int fail_count, num_checks, we_cnt;
   wcc_ctrl #(.WORDS(4), .UCODE_WORDS(4)) dut (.clock(clock), .srst(srst), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .wake_pin(wake_pin),
      .otp_rd_req(otp_rd_req), .otp_rd_addr(otp_rd_addr), .otp_rd_data(32'h0000_005a),
      .otp_rd_valid(otp_rd_valid), .ucode_ram_we(ucode_ram_we), .ucode_ram_addr(ucode_ram_addr),
      .long_preamble_param_set(lp_set), .sleep_after_receive(s_rx),
      .sleep_after_transmit(s_tx), .regulator_tuning(regulator_tuning),
      .always_on_config_zero_live(cfg0_live), .always_on_config_one_live(cfg1_live), .user_cfg(user_cfg),
      .wake_done(wake_done));
   // Free-running 100 MHz clock.
   initial
   begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // The OTP answers each request on the following cycle.
   always @(posedge clock)
   begin
      otp_rd_valid <= otp_rd_req;
      if (ucode_ram_we === 1'b1) we_cnt++;
   end
   task automatic chk(input string nm, input logic [127:0] got, input logic [127:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // The master never assumes a latency; a wait ends on pready or at the bound of 50 cycles.
   task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
         chk("pready", pready, 1'b1);
      q = prdata;
      e_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Poll the command register until the given bits have cleared.
   task automatic poll(input logic [31:0] m);
      int n;
      n = 0;
      do
      begin
         apb(1'b0, IDX_CMD, 32'h0);
         n++;
      end while ((q & m) !== 32'h0 && n < 50);
      chk("cmd clear", q & m, 32'h0);
   endtask
   task automatic wake();
      int n;
      we_cnt = 0;
      @(posedge clock);
      wake_pin <= 1'b1;
      repeat (4) @(posedge clock);
      wake_pin <= 1'b0;
      n = 0;
      while (wake_done !== 1'b1 && n < 500)
      begin
         @(posedge clock);
         n++;
      end
      chk("wake done", wake_done, 1'b1);
   endtask
   task automatic t_cmds();
      for (int i = 0; i < 4; i++)
      begin
         saved[i*32+:32] = 32'ha5a5_0000 + 32'(i);
         apb(1'b1, IDX_USER_BASE + 8'(i), saved[i*32+:32]);
      end
      apb(1'b1, IDX_CMD, 32'h02);
      poll(32'h02);
      for (int i = 0; i < 4; i++) apb(1'b1, IDX_USER_BASE + 8'(i), 32'h0);
      apb(1'b1, IDX_CMD, 32'h01);
      poll(32'h01);
      chk("restored", user_cfg, saved);
      apb(1'b1, IDX_ADDR, 32'h04);
      apb(1'b1, IDX_CMD, 32'h88);
      poll(32'h08);
      apb(1'b0, IDX_RDAT, 32'h0);
      chk("direct byte", q[7:0], 8'h01);
      // A direct read without its enable must be ignored and leave its bit set.
      apb(1'b1, IDX_ADDR, 32'h00);
      apb(1'b1, IDX_CMD, 32'h08);
      repeat (4) @(posedge clock);
      apb(1'b0, IDX_CMD, 32'h0);
      chk("dread refused", q[7:0], 8'h08);
      apb(1'b0, IDX_RDAT, 32'h0);
      chk("rdat kept", q[7:0], 8'h01);
      apb(1'b1, IDX_CMD, 32'h00);
      apb(1'b1, IDX_CFG0, 32'h1234_5678);
      apb(1'b1, IDX_CFG1, 32'h9abc_def0);
      apb(1'b1, IDX_CMD, 32'h04);
      repeat (3) @(posedge clock);
      chk("live cfg0", cfg0_live, 32'h1234_5678);
      chk("live cfg1", cfg1_live, 32'h9abc_def0);
      apb(1'b0, IDX_CMD, 32'h0);
      chk("upload stays", q[2], 1'b1);
      apb(1'b1, IDX_CMD, 32'h00);
   endtask
   task automatic t_wakes();
      for (int i = 0; i < 4; i++) apb(1'b1, IDX_USER_BASE + 8'(i), 32'h5555_5555);
      apb(1'b1, IDX_WAKE_CFG, 32'h01c0);
      apb(1'b1, IDX_SLEEP, 32'h3);
      wake();
      chk("restore wake", user_cfg, saved);
      chk("long set", lp_set, 1'b1);
      chk("sleep kept", {s_rx, s_tx}, 2'h3);
      apb(1'b0, IDX_STATUS, 32'h0);
      chk("status long idle", q, 32'h0000_0002);
      apb(1'b1, IDX_WAKE_CFG, 32'h1800);
      wake();
      chk("default cfg", user_cfg, {4{USER_RST}});
      chk("default set", lp_set, 1'b0);
      chk("sleep cleared", {s_rx, s_tx}, 2'h0);
      chk("copy words", we_cnt, 4);
      chk("trim", regulator_tuning, 32'h0000_005a);
      apb(1'b0, 8'h05, 32'h0);
      chk("unmapped", e_q, 1'b1);
      chk("unmapped data", q, 32'h0000_0000);
   endtask
   // A wake pulse that lies wholly inside a clock-enable low span is never sampled.
   task automatic t_freeze();
      we_cnt = 0;
      @(posedge clock);
      ce <= 1'b0;
      wake_pin <= 1'b1;
      repeat (6) @(posedge clock);
      wake_pin <= 1'b0;
      repeat (2) @(posedge clock);
      ce <= 1'b1;
      repeat (30) @(posedge clock);
      chk("frozen wake", we_cnt, 0);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Main sequence after an eight-cycle reset.
   initial
   begin
      {srst, psel, penable, pwrite, wake_pin, paddr, pwdata} = {1'b1, 46'h0};
      ce = 1'b1;
      repeat (8) @(posedge clock);
      srst <= 1'b0;
      apb(1'b0, IDX_WAKE_CFG, 32'h0);
      chk("wcfg reset", q, {16'h0, WCFG_RST});
      apb(1'b0, IDX_CMD, 32'h0);
      chk("cmd reset", q, {24'h0, CMD_RST});
      chk("otp addr", otp_rd_addr, OTP_TRIM_ADDR);
      t_cmds();
      t_wakes();
      t_freeze();
      give_verdict();
   end
   // Watchdog well beyond the few hundred cycles the tests need.
   initial
   begin
      repeat (20000) @(posedge clock);
      fail_count++;
      give_verdict();
   end
endmodule
`default_nettype wire

// ### testbench/wcc_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module wcc_ctrl_monitor #(
   parameter int UCODE_WORDS = 64
)(
   input wire logic        clock,            // System clock.
   input wire logic        srst,             // Synchronous reset.
   input wire logic        ce,               // Clock enable.
   input wire logic        psel,             // APB select.
   input wire logic        penable,          // APB enable.
   input wire logic        pready,           // APB ready.
   input wire logic        pslverr,          // APB error.
   input wire logic        otp_rd_req,       // OTP read pulse.
   input wire logic [7:0]  otp_rd_addr,      // OTP word address.
   input wire logic [31:0] otp_rd_data,      // OTP data.
   input wire logic        otp_rd_valid,     // OTP data valid.
   input wire logic        ucode_ram_we,     // Microcode write.
   input wire logic [15:0] ucode_ram_addr,   // Microcode address.
   input wire logic [31:0] regulator_tuning, // Regulator trim.
   input wire logic        wake_done         // Wake complete.
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   // One wait state, then a single-cycle answer.
   property p_ready_wait; psel && penable && !pready && ce |=> pready; endproperty
   property p_ready_pulse; pready && ce |=> !pready; endproperty
   property p_err_pulse; pslverr |-> pready; endproperty
   property p_otp_addr; otp_rd_req |-> otp_rd_addr == 8'h04; endproperty
   property p_trim_load; otp_rd_valid |=> regulator_tuning == $past(otp_rd_data); endproperty
   property p_ucode_start; $rose(ucode_ram_we) |-> ucode_ram_addr == 16'h0000; endproperty
   property p_ucode_step;
      ucode_ram_we && ucode_ram_addr < UCODE_WORDS - 1
         |=> ucode_ram_we && ucode_ram_addr == $past(ucode_ram_addr) + 16'h0001;
   endproperty
   property p_done_clean; wake_done |-> !ucode_ram_we && !otp_rd_req; endproperty
   property p_done_pulse; wake_done && ce |=> !wake_done; endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("late APB ready");
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
   a_err_pulse: assert property (p_err_pulse) else $error("error without ready");
   a_otp_addr: assert property (p_otp_addr) else $error("wrong OTP word");
   a_trim_load: assert property (p_trim_load) else $error("trim not loaded");
   a_ucode_start: assert property (p_ucode_start) else $error("copy start");
   a_ucode_step: assert property (p_ucode_step) else $error("copy broken");
   a_done_clean: assert property (p_done_clean) else $error("early done");
   a_done_pulse: assert property (p_done_pulse) else $error("done held");
   // Main scenarios reached.
   c_done: cover property (wake_done);
   c_err: cover property (pslverr);
   c_copy: cover property ($rose(ucode_ram_we));
endmodule
bind wcc_ctrl wcc_ctrl_monitor #(.UCODE_WORDS(UCODE_WORDS)) u_mon (.clock, .srst, .ce, .psel,
   .penable, .pready, .pslverr, .otp_rd_req, .otp_rd_addr, .otp_rd_data, .otp_rd_valid,
   .ucode_ram_we, .ucode_ram_addr, .regulator_tuning, .wake_done);
`default_nettype wire
